// File: logic/itp_pkg.sv
// constants shared by both ends of the interval timer program/read port
package itp_pkg;
    localparam int ITP_NUM_CTR = 3;
    // device port addresses
    localparam logic [1:0] ITP_ADDR_CTR0 = 2'h0;
    localparam logic [1:0] ITP_ADDR_CTR1 = 2'h1;
    localparam logic [1:0] ITP_ADDR_CTR2 = 2'h2;
    localparam logic [1:0] ITP_ADDR_CTRL = 2'h3;
    // control word fields
    localparam int ITP_SEL_POS = 6;
    localparam int ITP_ACC_POS = 4;
    localparam int ITP_MODE_POS = 1;
    localparam int ITP_BCD_POS = 0;
    localparam int ITP_RB_COUNT_N_POS = 5;
    localparam int ITP_RB_STATUS_N_POS = 4;
    localparam int ITP_RB_CTR0_POS = 1;
    localparam logic [1:0] ITP_SEL_READBACK = 2'h3;
    localparam logic [1:0] ITP_ACC_LATCH = 2'h0;
    localparam logic [1:0] ITP_ACC_LOW = 2'h1;
    localparam logic [1:0] ITP_ACC_HIGH = 2'h2;
    localparam logic [1:0] ITP_ACC_BOTH = 2'h3;
    localparam logic [7:0] ITP_LATCH_MASK = 8'hF0;
    localparam logic [7:0] ITP_READBACK_MASK = 8'hFE;
    // reset values
    localparam logic [7:0] ITP_BYTE_RST = 8'h00;
    localparam logic [15:0] ITP_WORD_RST = 16'h0000;
    // host register offsets
    localparam logic [2:0] ITP_HREG_TARGET = 3'h0;
    localparam logic [2:0] ITP_HREG_WRITE = 3'h1;
    localparam logic [2:0] ITP_HREG_READ = 3'h2;
    localparam logic [2:0] ITP_HREG_STATUS = 3'h3;
    localparam logic [2:0] ITP_HREG_RDATA = 3'h4;
    localparam int ITP_HSTAT_BUSY_POS = 0;
    localparam int ITP_HSTAT_REFUSED_POS = 1;

    typedef enum logic [2:0] {
        ITP_MODE0 = 3'h0,
        ITP_MODE1 = 3'h1,
        ITP_MODE2 = 3'h2,
        ITP_MODE3 = 3'h3,
        ITP_MODE4 = 3'h4,
        ITP_MODE5 = 3'h5
    } itp_mode_t;

    // x10 and x11 fold onto modes 2 and 3
    function automatic itp_mode_t itp_mode_decode(input logic [2:0] m);
        if (m[1]) begin
            return itp_mode_t'({1'b0, m[1:0]});
        end
        return itp_mode_t'(m);
    endfunction : itp_mode_decode
endpackage : itp_pkg

// File: logic/itp_bus_if.sv
// 8-bit chip-select bus between host controller and timer
`timescale 1ns/10ps
interface itp_bus_if;
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic [1:0] addr;
    logic [7:0] host_data;
    logic host_data_oe;
    logic [7:0] dev_data;
    logic dev_data_oe;

    modport dev (
        input cs_n, rd_n, wr_n, addr, host_data, host_data_oe,
        output dev_data, dev_data_oe
    );
    modport host (
        output cs_n, rd_n, wr_n, addr, host_data, host_data_oe,
        input dev_data, dev_data_oe
    );
endinterface : itp_bus_if

// File: logic/itp_timer_dev.sv
// three-channel interval timer: program, latch and read-back port
`timescale 1ns/10ps
module itp_timer_dev
    import itp_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_i,
    // host bus
    itp_bus_if.dev bus,
    // counter pins
    input wire logic [ITP_NUM_CTR-1:0] ctr_clk_i,
    input wire logic [ITP_NUM_CTR-1:0] ctr_gate_i,
    output logic [ITP_NUM_CTR-1:0] ctr_out_o,
    output itp_mode_t ctr_mode_o [ITP_NUM_CTR]
);
    localparam int N = ITP_NUM_CTR;

    // decrement, one decade per nibble when decimal
    function automatic logic [15:0] itp_count_down(input logic [15:0] v, input logic bcd);
        logic [15:0] r;
        logic borrow;
        r = v;
        borrow = 1'b1;
        if (!bcd) begin
            r = v - 16'h0001;
        end else begin
            for (int k = 0; k < 4; k++) begin
                if (borrow) begin
                    if (v[4*k +: 4] == 4'h0) begin
                        r[4*k +: 4] = 4'h9;
                    end else begin
                        r[4*k +: 4] = v[4*k +: 4] - 4'h1;
                        borrow = 1'b0;
                    end
                end
            end
        end
        return r;
    endfunction : itp_count_down

    logic wr_take;
    logic rd_take;
    logic [7:0] d;
    logic [1:0] sel;
    logic [1:0] acc_field;

    // per-counter programming state
    logic [1:0] access_reg [N];
    logic [2:0] mode_bits_reg [N];
    logic bcd_reg [N];
    logic [7:0] preset_low_byte [N];
    logic [7:0] preset_high_byte [N];
    logic wr_high_next_reg [N];
    logic load_pend_reg [N];
    logic null_count_reg [N];
    // core and snapshot state
    logic [15:0] core_reg [N];
    logic armed_reg [N];
    logic [N-1:0] clk_prev_reg;
    logic [15:0] count_snapshot_latch [N];
    logic snap_held_reg [N];
    logic [7:0] status_reg [N];
    logic status_held_reg [N];
    logic rd_high_next_reg [N];
    logic [7:0] dev_data_reg;
    logic dev_oe_reg;

    // decoded strobes
    logic [N-1:0] prog_s;
    logic [N-1:0] latch_cnt_s;
    logic [N-1:0] latch_sts_s;
    logic [N-1:0] cnt_wr_s;
    logic [N-1:0] cnt_rd_s;
    logic [N-1:0] tick_s;

    assign wr_take = !bus.cs_n && !bus.wr_n && bus.rd_n;
    assign rd_take = !bus.cs_n && !bus.rd_n && bus.wr_n;
    assign d = bus.host_data;
    assign sel = d[ITP_SEL_POS +: 2];
    assign acc_field = d[ITP_ACC_POS +: 2];

    always_comb begin
        for (int c = 0; c < N; c++) begin
            prog_s[c] = 1'b0;
            latch_cnt_s[c] = 1'b0;
            latch_sts_s[c] = 1'b0;
            cnt_wr_s[c] = 1'b0;
            cnt_rd_s[c] = 1'b0;
            tick_s[c] = ctr_clk_i[c] && !clk_prev_reg[c];
            if (wr_take && bus.addr == ITP_ADDR_CTRL) begin
                if (sel == ITP_SEL_READBACK) begin
                    if (d[ITP_RB_CTR0_POS + c]) begin
                        latch_cnt_s[c] = !d[ITP_RB_COUNT_N_POS];
                        latch_sts_s[c] = !d[ITP_RB_STATUS_N_POS];
                    end
                end else if (sel == 2'(c)) begin
                    latch_cnt_s[c] = (acc_field == ITP_ACC_LATCH);
                    prog_s[c] = (acc_field != ITP_ACC_LATCH);
                end
            end else if (bus.addr == 2'(c)) begin
                // an unprogrammed counter takes no count
                cnt_wr_s[c] = wr_take && access_reg[c] != ITP_ACC_LATCH;
                cnt_rd_s[c] = rd_take;
            end
        end
    end

    // programming and preset loading; a latch command touches none of this
    always_ff @(posedge ref_clk_i) begin
        for (int c = 0; c < N; c++) begin
            if (reset_i) begin
                access_reg[c] <= ITP_ACC_LATCH;
                mode_bits_reg[c] <= 3'h0;
                bcd_reg[c] <= 1'b0;
                preset_low_byte[c] <= ITP_BYTE_RST;
                preset_high_byte[c] <= ITP_BYTE_RST;
                wr_high_next_reg[c] <= 1'b0;
                load_pend_reg[c] <= 1'b0;
                null_count_reg[c] <= 1'b0;
            end else begin
                if (tick_s[c] && load_pend_reg[c]) begin
                    load_pend_reg[c] <= 1'b0;
                    null_count_reg[c] <= 1'b0;
                end
                if (prog_s[c]) begin
                    access_reg[c] <= acc_field;
                    mode_bits_reg[c] <= d[ITP_MODE_POS +: 3];
                    bcd_reg[c] <= d[ITP_BCD_POS];
                    wr_high_next_reg[c] <= 1'b0;
                    load_pend_reg[c] <= 1'b0;
                    null_count_reg[c] <= 1'b1;
                end else if (cnt_wr_s[c]) begin
                    case (access_reg[c])
                        ITP_ACC_LOW: begin
                            preset_low_byte[c] <= d;
                            preset_high_byte[c] <= ITP_BYTE_RST;
                            load_pend_reg[c] <= 1'b1;
                            null_count_reg[c] <= 1'b1;
                        end
                        ITP_ACC_HIGH: begin
                            preset_high_byte[c] <= d;
                            preset_low_byte[c] <= ITP_BYTE_RST;
                            load_pend_reg[c] <= 1'b1;
                            null_count_reg[c] <= 1'b1;
                        end
                        default: begin
                            // write toggle kept apart from the read toggle
                            wr_high_next_reg[c] <= !wr_high_next_reg[c];
                            if (wr_high_next_reg[c]) begin
                                preset_high_byte[c] <= d;
                                load_pend_reg[c] <= 1'b1;
                                null_count_reg[c] <= 1'b1;
                            end else begin
                                preset_low_byte[c] <= d;
                                load_pend_reg[c] <= 1'b0;
                            end
                        end
                    endcase
                end
            end
        end
    end

    // down-count core; mode-specific output shaping is not modelled
    always_ff @(posedge ref_clk_i) begin
        for (int c = 0; c < N; c++) begin
            if (reset_i) begin
                core_reg[c] <= ITP_WORD_RST;
                armed_reg[c] <= 1'b0;
                clk_prev_reg[c] <= 1'b0;
                ctr_out_o[c] <= 1'b0;
                ctr_mode_o[c] <= ITP_MODE0;
            end else begin
                clk_prev_reg[c] <= ctr_clk_i[c];
                ctr_mode_o[c] <= itp_mode_decode(mode_bits_reg[c]);
                ctr_out_o[c] <= armed_reg[c] && core_reg[c] == ITP_WORD_RST;
                if (prog_s[c]) begin
                    armed_reg[c] <= 1'b0;
                end else if (tick_s[c]) begin
                    if (load_pend_reg[c]) begin
                        // both halves enter the core in one step
                        core_reg[c] <= {preset_high_byte[c], preset_low_byte[c]};
                        armed_reg[c] <= 1'b1;
                    end else if (armed_reg[c] && ctr_gate_i[c]) begin
                        core_reg[c] <= itp_count_down(core_reg[c], bcd_reg[c]);
                    end
                end
            end
        end
    end

    // snapshot, status latch and read byte sequencing
    always_ff @(posedge ref_clk_i) begin
        for (int c = 0; c < N; c++) begin
            if (reset_i) begin
                count_snapshot_latch[c] <= ITP_WORD_RST;
                snap_held_reg[c] <= 1'b0;
                status_reg[c] <= ITP_BYTE_RST;
                status_held_reg[c] <= 1'b0;
                rd_high_next_reg[c] <= 1'b0;
            end else begin
                if (!snap_held_reg[c]) begin
                    count_snapshot_latch[c] <= core_reg[c];
                end
                if (prog_s[c]) begin
                    snap_held_reg[c] <= 1'b0;
                    status_held_reg[c] <= 1'b0;
                    rd_high_next_reg[c] <= 1'b0;
                end else begin
                    if (latch_cnt_s[c] && !snap_held_reg[c]) begin
                        snap_held_reg[c] <= 1'b1;
                    end
                    if (latch_sts_s[c] && !status_held_reg[c]) begin
                        status_held_reg[c] <= 1'b1;
                        status_reg[c] <= {ctr_out_o[c], null_count_reg[c], access_reg[c],
                                          mode_bits_reg[c], bcd_reg[c]};
                    end
                    if (cnt_rd_s[c]) begin
                        if (status_held_reg[c]) begin
                            // latched status always goes out before the count
                            status_held_reg[c] <= latch_sts_s[c];
                        end else if (access_reg[c] == ITP_ACC_BOTH) begin
                            rd_high_next_reg[c] <= !rd_high_next_reg[c];
                            if (rd_high_next_reg[c]) begin
                                snap_held_reg[c] <= 1'b0;
                            end
                        end else begin
                            snap_held_reg[c] <= 1'b0;
                        end
                    end
                end
            end
        end
    end

    // read answer one cycle after the strobe, driven for that cycle only
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            dev_data_reg <= ITP_BYTE_RST;
            dev_oe_reg <= 1'b0;
        end else begin
            dev_oe_reg <= 1'b0;
            for (int c = 0; c < N; c++) begin
                if (cnt_rd_s[c]) begin
                    dev_oe_reg <= 1'b1;
                    if (status_held_reg[c]) begin
                        dev_data_reg <= status_reg[c];
                    end else if (access_reg[c] == ITP_ACC_HIGH
                                 || (access_reg[c] == ITP_ACC_BOTH && rd_high_next_reg[c])) begin
                        dev_data_reg <= count_snapshot_latch[c][15:8];
                    end else begin
                        dev_data_reg <= count_snapshot_latch[c][7:0];
                    end
                end
            end
        end
    end

    assign bus.dev_data = dev_data_reg;
    assign bus.dev_data_oe = dev_oe_reg;
endmodule : itp_timer_dev

// File: logic/itp_timer_host.sv
// host controller that drives the timer bus from a software register port
`timescale 1ns/10ps
module itp_timer_host
    import itp_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_i,
    // software register port
    input wire logic [2:0] sw_addr_i,
    input wire logic [7:0] sw_wdata_i,
    input wire logic sw_wr_i,
    input wire logic sw_rd_i,
    output logic [7:0] sw_rdata_o,
    // timer bus
    itp_bus_if.host bus
);
    typedef enum logic [1:0] {
        ITP_H_IDLE = 2'b00,
        ITP_H_DRIVE = 2'b01,
        ITP_H_CAPTURE = 2'b11
    } itp_hstate_t;

    itp_hstate_t state_reg;
    logic [1:0] target_reg;
    logic [7:0] rdata_reg;
    logic refused_reg;
    logic [1:0] fmt_reg [ITP_NUM_CTR];
    logic cs_n_reg;
    logic rd_n_reg;
    logic wr_n_reg;
    logic [1:0] addr_reg;
    logic [7:0] hdata_reg;
    logic hoe_reg;

    logic go_wr;
    logic go_rd;
    logic to_ctrl;
    logic fmt_ok;
    logic refuse;
    logic [7:0] clean_cw;

    assign go_wr = sw_wr_i && sw_addr_i == ITP_HREG_WRITE && state_reg == ITP_H_IDLE;
    assign go_rd = sw_wr_i && sw_addr_i == ITP_HREG_READ && state_reg == ITP_H_IDLE;
    assign to_ctrl = target_reg == ITP_ADDR_CTRL;
    assign fmt_ok = to_ctrl || fmt_reg[target_reg] != ITP_ACC_LATCH;
    // count access before a control word, or a read of the control port
    assign refuse = (go_wr && !fmt_ok) || (go_rd && (to_ctrl || !fmt_ok));

    // don't-care bits forced to zero
    always_comb begin
        clean_cw = sw_wdata_i;
        if (sw_wdata_i[ITP_SEL_POS +: 2] == ITP_SEL_READBACK) begin
            clean_cw = sw_wdata_i & ITP_READBACK_MASK;
        end else if (sw_wdata_i[ITP_ACC_POS +: 2] == ITP_ACC_LATCH) begin
            clean_cw = sw_wdata_i & ITP_LATCH_MASK;
        end else if (sw_wdata_i[ITP_MODE_POS + 1]) begin
            clean_cw[ITP_MODE_POS + 2] = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            target_reg <= ITP_ADDR_CTR0;
            refused_reg <= 1'b0;
            for (int c = 0; c < ITP_NUM_CTR; c++) begin
                fmt_reg[c] <= ITP_ACC_LATCH;
            end
        end else begin
            if (sw_wr_i && sw_addr_i == ITP_HREG_TARGET) begin
                target_reg <= sw_wdata_i[1:0];
            end
            if (sw_wr_i && sw_addr_i == ITP_HREG_STATUS) begin
                refused_reg <= 1'b0;
            end
            if (refuse) begin
                refused_reg <= 1'b1;
            end
            // remember each counter's byte format to refuse count access until one is set
            if (go_wr && to_ctrl && clean_cw[ITP_SEL_POS +: 2] != ITP_SEL_READBACK
                && clean_cw[ITP_ACC_POS +: 2] != ITP_ACC_LATCH) begin
                fmt_reg[clean_cw[ITP_SEL_POS +: 2]] <= clean_cw[ITP_ACC_POS +: 2];
            end
        end
    end

    // bus sequencer: one strobe cycle, then one capture cycle for reads
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            state_reg <= ITP_H_IDLE;
            cs_n_reg <= 1'b1;
            rd_n_reg <= 1'b1;
            wr_n_reg <= 1'b1;
            addr_reg <= ITP_ADDR_CTR0;
            hdata_reg <= ITP_BYTE_RST;
            hoe_reg <= 1'b0;
            rdata_reg <= ITP_BYTE_RST;
        end else begin
            case (state_reg)
                ITP_H_IDLE: begin
                    if ((go_wr || go_rd) && !refuse) begin
                        state_reg <= ITP_H_DRIVE;
                        cs_n_reg <= 1'b0;
                        addr_reg <= target_reg;
                        wr_n_reg <= !go_wr;
                        rd_n_reg <= !go_rd;
                        hoe_reg <= go_wr;
                        hdata_reg <= to_ctrl ? clean_cw : sw_wdata_i;
                    end
                end
                ITP_H_DRIVE: begin
                    cs_n_reg <= 1'b1;
                    wr_n_reg <= 1'b1;
                    rd_n_reg <= 1'b1;
                    hoe_reg <= 1'b0;
                    state_reg <= rd_n_reg ? ITP_H_IDLE : ITP_H_CAPTURE;
                end
                ITP_H_CAPTURE: begin
                    if (bus.dev_data_oe) begin
                        rdata_reg <= bus.dev_data;
                    end
                    state_reg <= ITP_H_IDLE;
                end
                default: begin
                    state_reg <= ITP_H_IDLE;
                end
            endcase
        end
    end

    // software read data, one cycle after the strobe
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            sw_rdata_o <= ITP_BYTE_RST;
        end else if (sw_rd_i) begin
            if (sw_addr_i == ITP_HREG_TARGET) begin
                sw_rdata_o <= {6'h00, target_reg};
            end else if (sw_addr_i == ITP_HREG_STATUS) begin
                sw_rdata_o <= {6'h00, refused_reg, state_reg != ITP_H_IDLE};
            end else if (sw_addr_i == ITP_HREG_RDATA) begin
                sw_rdata_o <= rdata_reg;
            end else begin
                sw_rdata_o <= ITP_BYTE_RST;
            end
        end else begin
            sw_rdata_o <= ITP_BYTE_RST;
        end
    end

    assign bus.cs_n = cs_n_reg;
    assign bus.rd_n = rd_n_reg;
    assign bus.wr_n = wr_n_reg;
    assign bus.addr = addr_reg;
    assign bus.host_data = hdata_reg;
    assign bus.host_data_oe = hoe_reg;
endmodule : itp_timer_host

// File: testbench/itp_bus_properties.sv
// concurrent checks on the bus between host and device ends
`timescale 1ns/10ps
module itp_bus_properties (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_i,
    // bus signals
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [1:0] addr,
    input wire logic host_data_oe,
    input wire logic dev_data_oe
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);

    strobe_select_a: assert property ((!rd_n || !wr_n) |-> !cs_n && (rd_n || wr_n))
        else $error("strobe without select");
    rd_pulse_a: assert property (!rd_n |=> rd_n)
        else $error("read strobe too long");
    wr_pulse_a: assert property (!wr_n |=> wr_n)
        else $error("write strobe too long");
    read_answer_a: assert property (!cs_n && !rd_n && addr != 2'h3 |=> dev_data_oe)
        else $error("read not answered");
    answer_cause_a: assert property (dev_data_oe |-> $past(!cs_n && !rd_n))
        else $error("answer without read");
    no_contention_a: assert property (!(dev_data_oe && host_data_oe))
        else $error("both ends drive data");
    host_drive_a: assert property (!cs_n && !wr_n |-> host_data_oe)
        else $error("write without data");
    host_release_a: assert property (host_data_oe |-> !cs_n && !wr_n ##1 !host_data_oe)
        else $error("host holds data");
endmodule : itp_bus_properties

// File: testbench/interval_timer_program_read_port_tb.sv
// bench: host controller and timer device joined by the bus
`timescale 1ns/10ps
module interval_timer_program_read_port_tb;
    import itp_pkg::*;
    logic ref_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [2:0] sw_addr_i = 3'h0;
    logic [7:0] sw_wdata_i = 8'h00;
    logic sw_wr_i = 1'b0;
    logic sw_rd_i = 1'b0;
    logic [7:0] sw_rdata_o;
    logic [2:0] ctr_clk_i = 3'h0;
    logic [2:0] ctr_gate_i = 3'h0;
    logic [2:0] ctr_out_o;
    itp_mode_t ctr_mode_o [ITP_NUM_CTR];
    integer err_total = 0;
    integer checked = 0;
    integer seed = 32'h2A0549FA;
    logic [15:0] cnt;
    logic [15:0] nxt;
    logic [15:0] got;
    logic [7:0] b;

    itp_bus_if bus ();
    itp_timer_dev itp_timer_dev_inst (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .bus(bus),
        .ctr_clk_i(ctr_clk_i), .ctr_gate_i(ctr_gate_i), .ctr_out_o(ctr_out_o),
        .ctr_mode_o(ctr_mode_o));
    itp_timer_host itp_timer_host_inst (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
        .sw_addr_i(sw_addr_i), .sw_wdata_i(sw_wdata_i), .sw_wr_i(sw_wr_i), .sw_rd_i(sw_rd_i),
        .sw_rdata_o(sw_rdata_o), .bus(bus));
    itp_bus_properties itp_bus_properties_inst (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
        .cs_n(bus.cs_n), .rd_n(bus.rd_n), .wr_n(bus.wr_n), .addr(bus.addr),
        .host_data_oe(bus.host_data_oe), .dev_data_oe(bus.dev_data_oe));

    initial begin
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic results();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : results

    task automatic sw_write(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        sw_addr_i <= a;
        sw_wdata_i <= d;
        sw_wr_i <= 1'b1;
        @(posedge ref_clk_i);
        sw_wr_i <= 1'b0;
    endtask : sw_write

    task automatic sw_read(input logic [2:0] a, output logic [7:0] d);
        @(posedge ref_clk_i);
        sw_addr_i <= a;
        sw_rd_i <= 1'b1;
        @(posedge ref_clk_i);
        sw_rd_i <= 1'b0;
        #1 d = sw_rdata_o;
    endtask : sw_read

    // polls busy; a stuck controller ends the run
    task automatic wait_idle();
        logic [7:0] s = 8'hFF;
        for (int i = 0; i < 40 && s[0] !== 1'b0; i++) sw_read(ITP_HREG_STATUS, s);
        if (s[0] !== 1'b0) begin
            err_total++;
            $display("[FAIL] %0t busy stuck", $time);
            results();
        end
    endtask : wait_idle

    task automatic dev_write(input logic [1:0] t, input logic [7:0] d);
        sw_write(ITP_HREG_TARGET, {6'h00, t});
        sw_write(ITP_HREG_WRITE, d);
        wait_idle();
    endtask : dev_write

    task automatic dev_read(input logic [1:0] t, output logic [7:0] d);
        sw_write(ITP_HREG_TARGET, {6'h00, t});
        sw_write(ITP_HREG_READ, 8'h00);
        wait_idle();
        sw_read(ITP_HREG_RDATA, d);
    endtask : dev_read

    // slow counter clock pulse, several reference cycles per phase
    task automatic pulse(input int c, input logic g);
        @(posedge ref_clk_i);
        ctr_gate_i[c] <= g;
        repeat (4) @(posedge ref_clk_i);
        ctr_clk_i[c] <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        ctr_clk_i[c] <= 1'b0;
        ctr_gate_i[c] <= 1'b0;
        repeat (4) @(posedge ref_clk_i);
    endtask : pulse

    function automatic logic [2:0] exp_mode(input logic [2:0] m);
        return m[1] ? {1'b0, m[1:0]} : m;
    endfunction : exp_mode

    initial begin
        repeat (16) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        sw_write(ITP_HREG_TARGET, 8'h01);
        sw_write(ITP_HREG_WRITE, 8'h5A);
        sw_read(ITP_HREG_STATUS, b);
        check({15'h0000, b[ITP_HSTAT_REFUSED_POS]}, 16'h0001);
        sw_write(ITP_HREG_STATUS, 8'h00);
        $display("refusal test done");
        for (int m = 0; m < 8; m++) begin
            dev_write(ITP_ADDR_CTRL, {2'(m % 3), ITP_ACC_BOTH, 3'(m), 1'b0});
            check(16'(ctr_mode_o[m % 3]), 16'(exp_mode(3'(m))));
        end
        $display("mode test done");
        repeat (4) begin
            cnt = 16'($random(seed)) | 16'h0100;
            nxt = 16'($random(seed));
            dev_write(ITP_ADDR_CTRL, {2'h0, ITP_ACC_BOTH, 3'h0, 1'b0});
            dev_write(ITP_ADDR_CTR0, cnt[7:0]);
            dev_write(ITP_ADDR_CTR0, cnt[15:8]);
            pulse(0, 1'b0);
            dev_write(ITP_ADDR_CTRL, 8'h00);
            pulse(0, 1'b1);
            // second latch must not replace the frozen count
            dev_write(ITP_ADDR_CTRL, 8'h00);
            dev_read(ITP_ADDR_CTR0, got[7:0]);
            dev_write(ITP_ADDR_CTR0, nxt[7:0]);
            dev_write(ITP_ADDR_CTRL, 8'h40);
            dev_read(ITP_ADDR_CTR0, got[15:8]);
            dev_write(ITP_ADDR_CTR0, nxt[15:8]);
            check(got, cnt);
            check(16'(ctr_mode_o[0]), 16'(ITP_MODE0));
            pulse(0, 1'b0);
            dev_read(ITP_ADDR_CTR0, got[7:0]);
            dev_read(ITP_ADDR_CTR0, got[15:8]);
            check(got, nxt);
        end
        $display("latch test done");
        b = 8'($random(seed)) | 8'h01;
        // a stale nonzero low byte would show up in the high byte read
        dev_write(ITP_ADDR_CTRL, {2'h2, ITP_ACC_LOW, 3'h0, 1'b0});
        dev_write(ITP_ADDR_CTR2, b);
        dev_write(ITP_ADDR_CTRL, {2'h2, ITP_ACC_HIGH, 3'h0, 1'b0});
        dev_write(ITP_ADDR_CTR2, b);
        pulse(2, 1'b0);
        pulse(2, 1'b1);
        dev_write(ITP_ADDR_CTRL, 8'h80);
        dev_read(ITP_ADDR_CTR2, got[7:0]);
        check({8'h00, got[7:0]}, {8'h00, b - 8'h01});
        $display("single byte test done");
        // count and status of counter 2 held together, status read first
        dev_write(ITP_ADDR_CTRL, 8'hC8);
        dev_read(ITP_ADDR_CTR2, got[7:0]);
        check({8'h00, got[7:0]}, {8'h00, 2'h0, ITP_ACC_HIGH, 4'h0});
        dev_read(ITP_ADDR_CTR2, got[15:8]);
        check({8'h00, got[15:8]}, {8'h00, b - 8'h01});
        $display("read-back test done");
        // decimal count: ten less one is 09, not 0F
        dev_write(ITP_ADDR_CTRL, {2'h1, ITP_ACC_LOW, 3'h0, 1'b1});
        dev_write(ITP_ADDR_CTR1, 8'h10);
        pulse(1, 1'b0);
        pulse(1, 1'b1);
        dev_read(ITP_ADDR_CTR1, got[7:0]);
        check({8'h00, got[7:0]}, 16'h0009);
        dev_write(ITP_ADDR_CTR1, 8'h01);
        pulse(1, 1'b0);
        check({15'h0000, ctr_out_o[1]}, 16'h0000);
        pulse(1, 1'b1);
        check({15'h0000, ctr_out_o[1]}, 16'h0001);
        check(16'(ctr_mode_o[1]), 16'(ITP_MODE0));
        $display("decimal and output test done");
        results();
    end
endmodule : interval_timer_program_read_port_tb
